// ===== testbench/shf_rx_model.sv
// Receiver model that rebuilds the sync header stream and its parity
`timescale 1ns/1ps
module shf_rx_model
  import shf_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire shf_out_t blk_out,
  input wire logic mb_start,
  output logic [0:31] stream,
  output logic [25:0] calc,
  output logic [25:0] prev,
  output logic hdr_bad
);
  logic [0:31] acc;
  logic [25:0] r;
  logic fb;
  int pos;
  // ==========================================
  // Collect one multiblock
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pos = 31;
      r = '0;
      hdr_bad = 1'b0;
      stream = '0;
      calc = '0;
      prev = '0;
    end
    else if (blk_out.valid)
    begin
      if (mb_start)
      begin
        pos = 0;
        r = '0;
      end
      else
        pos = pos + 1;
      acc[pos] = (blk_out.hdr == 2'h1);
      if (blk_out.hdr != 2'h1 && blk_out.hdr != 2'h2)
        hdr_bad = 1'b1;
      for (int i = 63; i >= 0; i--)
      begin
        fb = blk_out.data[i] ^ r[25];
        r = {r[24:0], 1'b0} ^ (fb ? 26'h0220211 : 26'h0000000);
      end
      if (pos == 31)
      begin
        stream = acc;
        prev = calc;
        calc = r;
      end
    end
  end
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the sync header stream framer
`timescale 1ns/1ps
module tb_top;
  import shf_pkg::*;
  logic mclk, nrst, link_en, sysref, mb_start, fec_active, hdr_bad;
  logic [1:0] mode;
  logic [4:0] emb;
  shf_blk_t blk_in;
  shf_out_t blk_out;
  logic [0:31] stream;
  logic [25:0] calc, prev, p;
  int err_total, checked;
  shf_framer i_dut (.mclk(mclk), .nrst(nrst), .link_en(link_en), .sysref(sysref),
    .sync_header_mode_select(mode), .emb_len_m1(emb), .blk_in(blk_in), .blk_out(blk_out),
    .mb_start(mb_start), .fec_active(fec_active));
  shf_rx_model i_rx (.mclk(mclk), .nrst(nrst), .blk_out(blk_out), .mb_start(mb_start),
    .stream(stream), .calc(calc), .prev(prev), .hdr_bad(hdr_bad));
  // ==========================================
  // Clock, verdict and compare
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic end_of_test();
    if (err_total == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  // ==========================================
  // Drivers
  task automatic restart(input logic [1:0] m, input logic [4:0] e);
    @(posedge mclk);
    link_en <= 1'b0;
    mode <= m;
    emb <= e;
    @(posedge mclk);
    link_en <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask
  task automatic send(input int s, input int n);
    for (int b = 0; b < n; b++)
    begin
      @(posedge mclk);
      blk_in <= '{data: {8{s[3:0], b[3:0]}} ^ 64'hF00D123456789ABC, valid: 1'b1};
    end
    @(posedge mclk);
    blk_in.valid <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  // One whole multiblock, then its stream fields are judged
  task automatic mb(input int s, input logic [25:0] par, input logic eo);
    send(s, 32);
    chk("parity", par, {stream[0:21], stream[23:26]});
    chk("pilot", 5'b00001, stream[27:31]);
    chk("eoemb", eo, stream[22]);
    chk("hdr_bad", 1'b0, hdr_bad);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_fec();
    restart(2'h2, 5'h01);
    mb(1, 26'h0, 1'b0);
    chk("fec_active", 1'b1, fec_active);
    p = calc;
    mb(2, p, 1'b1);
    p = calc;
    mb(3, p, 1'b0);
  endtask
  // Other mode codes keep pilot and flag, parity zero
  task automatic t_mode();
    for (int m = 0; m < 4; m++)
    begin
      if (m != 2)
      begin
        restart(m[1:0], 5'h00);
        mb(4, 26'h0, 1'b1);
        mb(5, 26'h0, 1'b1);
        chk("fec_active", 1'b0, fec_active);
      end
    end
  endtask
  // Sysref mid multiblock restarts phase and parity
  task automatic t_sysref();
    restart(2'h2, 5'h00);
    mb(6, 26'h0, 1'b1);
    send(7, 10);
    @(posedge mclk);
    sysref <= 1'b1;
    @(posedge mclk);
    sysref <= 1'b0;
    mb(8, 26'h0, 1'b1);
    p = calc;
    mb(9, p, 1'b1);
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial
  begin
    err_total = 0;
    checked = 0;
    nrst = 1'b0;
    link_en = 1'b0;
    sysref = 1'b0;
    mode = 2'h0;
    emb = 5'h00;
    blk_in = '0;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    t_fec();
    t_mode();
    t_sysref();
    end_of_test();
  end
  // Run needs about 5 us; a hang is cut well after
  initial
  begin
    #50000;
    err_total++;
    end_of_test();
  end
endmodule

// ===== verilog/shf_cfg.svh
// Constants for the sync header stream framer
`ifndef SHF_CFG_SVH
`define SHF_CFG_SVH
`define SHF_MODE_FEC 2'h2
`define SHF_BLK_PER_MB 6'h20
`define SHF_PAR_W 26
`define SHF_POLY 26'h0220211
`define SHF_PILOT 5'h01
`define SHF_EOEMB_POS 5'h16
`define SHF_HDR_ONE 2'h1
`define SHF_HDR_ZERO 2'h2
`endif

// ===== verilog/shf_framer.sv
// Sync header stream framer with FEC parity generation
`timescale 1ns/1ps
module shf_framer
  import shf_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic link_en,
  input wire logic sysref,
  input wire logic [1:0] sync_header_mode_select,
  input wire logic [4:0] emb_len_m1,
  input wire shf_blk_t blk_in,
  output shf_out_t blk_out,
  output logic mb_start,
  output logic fec_active
);
  // ==========================================
  // Parity arithmetic
  // One bit per step of the LFSR, unrolled over 64 payload bits.
  function automatic logic [25:0] par_step64(input logic [25:0] s, input logic [63:0] d);
    logic [25:0] r;
    logic fb;
    r = s;
    for (int i = 63; i >= 0; i--)
    begin
      fb = r[25] ^ d[i];
      r = {r[24:0], 1'b0};
      if (fb)
      begin
        r = r ^ `SHF_POLY;
      end
    end
    return r;
  endfunction

  // Stream position to header bit mapping
  function automatic logic stream_bit(input logic [4:0] pos, input logic [25:0] p, input logic eoemb);
    logic b;
    b = 1'b0;
    if (pos <= 5'd21)
      b = p[5'd25 - pos];
    else if (pos == `SHF_EOEMB_POS)
      b = eoemb;
    else if (pos <= 5'd26)
      b = p[5'd26 - pos];
    else
      b = (pos == 5'd31);
    return b;
  endfunction

  // ==========================================
  // State
  shf_state_t state;
  logic [4:0] blk_cnt;
  logic [4:0] mb_cnt;
  logic [25:0] par_acc;
  logic [25:0] par_tx;
  logic sent_bit;
  logic [4:0] last_pos;
  logic last_eoemb;

  wire logic fec_mode = (sync_header_mode_select == `SHF_MODE_FEC);
  wire logic eoemb_now = (mb_cnt == emb_len_m1);
  wire logic take = (state == SHF_RUN) && blk_in.valid;
  wire logic last_blk = (blk_cnt == 5'd31);

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      state <= SHF_IDLE;
    else if (!link_en)
      state <= SHF_IDLE;
    else
      state <= SHF_RUN;
  end

  // ==========================================
  // Block and multiblock counters
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      blk_cnt <= 5'h00;
      mb_cnt <= 5'h00;
    end
    else if (state == SHF_IDLE || sysref)
    begin
      blk_cnt <= 5'h00;
      mb_cnt <= 5'h00;
    end
    else if (take)
    begin
      blk_cnt <= blk_cnt + 5'd1;
      if (last_blk)
        mb_cnt <= eoemb_now ? 5'h00 : mb_cnt + 5'd1;
    end
  end

  // ==========================================
  // Parity accumulation and hand-off
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      par_acc <= 26'h0000000;
      par_tx <= 26'h0000000;
    end
    else if (state == SHF_IDLE || sysref)
    begin
      par_acc <= 26'h0000000;
      par_tx <= 26'h0000000;
    end
    else if (take)
    begin
      if (last_blk)
      begin
        par_tx <= par_step64(par_acc, blk_in.data);
        par_acc <= 26'h0000000;
      end
      else
        par_acc <= par_step64(par_acc, blk_in.data);
    end
  end

  // ==========================================
  // Output block with sync header
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      blk_out <= '0;
      mb_start <= 1'b0;
      fec_active <= 1'b0;
    end
    else
    begin
      fec_active <= fec_mode && (state == SHF_RUN);
      mb_start <= take && (blk_cnt == 5'h00);
      blk_out.valid <= take;
      if (take)
      begin
        blk_out.data <= blk_in.data;
        blk_out.hdr <= stream_bit(blk_cnt, fec_mode ? par_tx : 26'h0000000, eoemb_now)
          ? `SHF_HDR_ONE : `SHF_HDR_ZERO;
      end
    end
  end

  // ==========================================
  // Assertion helpers
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      sent_bit <= 1'b0;
      last_pos <= 5'h00;
      last_eoemb <= 1'b0;
    end
    else
    begin
      sent_bit <= stream_bit(blk_cnt, fec_mode ? par_tx : 26'h0000000, eoemb_now);
      last_pos <= blk_cnt;
      last_eoemb <= eoemb_now;
    end
  end

  property p_hdr_enc;
    @(posedge mclk) disable iff (!nrst) blk_out.valid |-> (blk_out.hdr == (sent_bit ? 2'h1 : 2'h2));
  endproperty
  a_hdr_enc: assert property (p_hdr_enc) else $error("bad header");
  property p_pilot;
    @(posedge mclk) disable iff (!nrst) blk_out.valid && last_pos >= 5'd27 |-> sent_bit == (last_pos == 5'd31);
  endproperty
  a_pilot: assert property (p_pilot) else $error("bad pilot");
  property p_eoemb;
    @(posedge mclk) disable iff (!nrst) blk_out.valid && last_pos == 5'd22 |-> sent_bit == last_eoemb;
  endproperty
  a_eoemb: assert property (p_eoemb) else $error("bad eoemb");
  property p_clear;
    @(posedge mclk) disable iff (!nrst) take && last_blk |=> par_acc == 26'h0000000;
  endproperty
  a_clear: assert property (p_clear) else $error("parity not cleared");
  property p_handoff;
    @(posedge mclk) disable iff (!nrst) take && last_blk && !sysref |=> par_tx == par_step64($past(par_acc), $past(blk_in.data));
  endproperty
  a_handoff: assert property (p_handoff) else $error("bad parity hand-off");
  property p_zero_first;
    @(posedge mclk) disable iff (!nrst) state == SHF_IDLE |=> par_tx == 26'h0000000;
  endproperty
  a_zero_first: assert property (p_zero_first) else $error("first parity not zero");
  property p_sysref;
    @(posedge mclk) disable iff (!nrst) sysref |=> blk_cnt == 5'h00 && mb_cnt == 5'h00;
  endproperty
  a_sysref: assert property (p_sysref) else $error("phase not reset");
  property p_mode;
    @(posedge mclk) disable iff (!nrst) state == SHF_RUN && fec_mode |=> fec_active;
  endproperty
  a_mode: assert property (p_mode) else $error("fec not active");
  property p_mb_len;
    @(posedge mclk) disable iff (!nrst) mb_start |=> !mb_start;
  endproperty
  a_mb_len: assert property (p_mb_len) else $error("mb length");
  c_mb: cover property (@(posedge mclk) disable iff (!nrst) mb_start);
  c_emb: cover property (@(posedge mclk) disable iff (!nrst) take && last_blk && eoemb_now);
  c_one: cover property (@(posedge mclk) disable iff (!nrst) blk_out.valid && blk_out.hdr == 2'h1);
endmodule

// ===== verilog/shf_pkg.sv
// Types for the sync header stream framer
`include "shf_cfg.svh"
package shf_pkg;
  typedef struct packed {
    logic [63:0] data;
    logic valid;
  } shf_blk_t;
  typedef struct packed {
    logic [1:0] hdr;
    logic [63:0] data;
    logic valid;
  } shf_out_t;
  typedef enum logic [1:0] {
    SHF_IDLE = 2'b01,
    SHF_RUN = 2'b10
  } shf_state_t;
endpackage
